// ==== core/bsps_defines.svh ====
// constants for the switch position scanner
// ====================
// Summary of operation
// (RULE1) scan period programmable 12..2000 ms, default 12 ms.
// (RULE2) capturing one strobe's data needs a fixed 12 ms window.
// (RULE3) software sets period at least 12 ms plus source settle time.
// (RULE4) longer periods sample only in the last 12 ms of each strobe.
// (RULE5) data code bit 4: 0 binary default, 1 BCD; switches need BCD.
// (RULE6) command mode bit 3: 0 absolute default, 1 incremental.
// (RULE7) absolute: forward if current below target, reverse if above.
// (RULE8) incremental: target equals current plus signed switch value.
// (RULE9) incremental: forward for positive sign, reverse for negative.
// (RULE10) incremental switch runs clear current coordinate at start.
// (RULE11) retention bit 0: 0 clears coordinate at start, 1 keeps it; code clears it only in incremental mode, absolute runs always keep it.
// (RULE12) single stage speed-only wiring ignores that stage's sign digit.
// (RULE13) default speed source is the strobed speed digits.
// (RULE14) alternative speed: one of four stored speeds, or serial speed.
// (RULE15) software confirms read data by monitor before starting motion.
// (RULE16) five active-low strobes in cyclic order, one period each.
// (RULE17) each strobe reads 8 position and 8 speed lines, two BCD digits.
// (RULE18) source drives digits of the active strobe, closed contact is 1.
// (RULE19) values latch only after all five strobes of one cycle sampled.
`ifndef BSPS_DEFINES_SVH
`define BSPS_DEFINES_SVH

`define BSPS_CLK_HZ        200000000
`define BSPS_MS_CYCLES     (`BSPS_CLK_HZ / 1000)
`define BSPS_SCAN_MIN_MS   12
`define BSPS_SCAN_MAX_MS   2000
`define BSPS_SCAN_DEF_MS   11'h00C
`define BSPS_READ_WIN_MS   12

`define BSPS_CFG_RETAIN_BIT 0
`define BSPS_CFG_MODE_BIT   3
`define BSPS_CFG_CODE_BIT   4
`define BSPS_CFG_RESET      8'h00

`define BSPS_REG_CFG       4'h0
`define BSPS_REG_SCAN      4'h4
`define BSPS_REG_SPDSEL    4'hC
`define BSPS_REG_MONPOS    5'h10
`define BSPS_REG_MONSPD    5'h14
`define BSPS_REG_CURPOS    5'h18
`define BSPS_REG_TARGET    5'h1C
`define BSPS_REG_STATUS    6'h20
`define BSPS_REG_STORED0   6'h24
`define BSPS_REG_SERSPD    6'h34

`endif

// ==== core/bsps_ms_tick.sv ====
// millisecond enable divider
`timescale 1ns/1ps
module bsps_ms_tick #(
  parameter int unsigned CYCLES = 200000
) (
  input  wire logic core_clk,  // system clock
  input  wire logic resetn,    // sync reset, active low
  output logic      msTick     // one-cycle pulse per millisecond
);
  localparam int unsigned W = $clog2(CYCLES);
  logic [W-1:0] count;

  if (CYCLES < 2) $error("CYCLES below 2");

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      count  <= '0;
      msTick <= 1'b0;
    end else if (count == W'(CYCLES - 1)) begin
      count  <= '0;
      msTick <= 1'b1;
    end else begin
      count  <= count + W'(1);
      msTick <= 1'b0;
    end
  end
endmodule : bsps_ms_tick

// ==== core/bsps_pkg.sv ====
// types for the switch position scanner
package bsps_pkg;
  typedef enum logic [1:0] {
    BSPS_SPD_SWITCH,
    BSPS_SPD_STORED,
    BSPS_SPD_SERIAL
  } bsps_spd_src_t;

  typedef enum logic [1:0] {
    BSPS_IDLE,
    BSPS_RUN_FWD,
    BSPS_RUN_REV
  } bsps_motion_t;
endpackage : bsps_pkg

// ==== core/bsps_scanner.sv ====
// switch scanner top: strobes, digit capture, motion command, AXI4-Lite
`timescale 1ns/1ps
`include "bsps_defines.svh"
module bsps_scanner
  import bsps_pkg::*;
#(
  parameter int unsigned MS_CYCLES = `BSPS_MS_CYCLES
) (
  input  wire logic        core_clk,       // 200 MHz clock
  input  wire logic        resetn,         // sync reset, active low
  // switch unit pins
  output logic [4:0]       strobeLineN,    // strobe 0..4, active low
  input  wire logic [7:0]  posDigitInN,    // position lines, active low
  input  wire logic [7:0]  spdDigitInN,    // speed lines, active low
  // drive side
  input  wire logic        autoStart,      // one-cycle start of auto run
  input  wire logic        stepFwd,        // coordinate +1 pulse
  input  wire logic        stepRev,        // coordinate -1 pulse
  input  wire logic [1:0]  speedSelIn,     // contact speed select
  output logic             cmdValid,       // full cycle captured
  output logic [1:0]       motionDir,      // 0 idle, 1 fwd, 2 rev
  output logic [31:0]      feedSpeed,      // chosen feed speed
  // AXI4-Lite slave
  input  wire logic [7:0]  s_axi_awaddr,   // write address
  input  wire logic        s_axi_awvalid,  // write address valid
  output logic             s_axi_awready,  // write address ready
  input  wire logic [31:0] s_axi_wdata,    // write data
  input  wire logic [3:0]  s_axi_wstrb,    // write strobes
  input  wire logic        s_axi_wvalid,   // write data valid
  output logic             s_axi_wready,   // write data ready
  output logic [1:0]       s_axi_bresp,    // write response
  output logic             s_axi_bvalid,   // write response valid
  input  wire logic        s_axi_bready,   // write response ready
  input  wire logic [7:0]  s_axi_araddr,   // read address
  input  wire logic        s_axi_arvalid,  // read address valid
  output logic             s_axi_arready,  // read address ready
  output logic [31:0]      s_axi_rdata,    // read data
  output logic [1:0]       s_axi_rresp,    // read response
  output logic             s_axi_rvalid,   // read data valid
  input  wire logic        s_axi_rready    // read data ready
);
  if (MS_CYCLES < 2) $error("MS_CYCLES below 2");

  // ====================
  // registers
  logic [7:0]    memorySwitchWord;
  logic [10:0]   switchScanPeriodParam;
  logic          speedOnlyStage;
  bsps_spd_src_t spdSrc;
  logic [31:0]   storedSpeed [4];
  logic [31:0]   serialSpeedCmd;
  logic [31:0]   monitorCmdPosition;
  logic [31:0]   monitorCmdSpeed;
  logic signed [31:0] curPos;
  logic signed [31:0] targetPos;
  bsps_motion_t  motion;

  // ====================
  // pin sync: three stages, taken when 2nd and 3rd agree
  logic [15:0] pinS1, pinS2, pinS3, pinStable;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pinS1     <= 16'h0000;
      pinS2     <= 16'h0000;
      pinS3     <= 16'h0000;
      pinStable <= 16'h0000;
    end else begin
      pinS1 <= ~{spdDigitInN, posDigitInN};  // closed contact = 1 [RULE18]
      pinS2 <= pinS1;
      pinS3 <= pinS2;
      for (int i = 0; i < 16; i++) begin
        if (pinS2[i] == pinS3[i]) pinStable[i] <= pinS3[i];
      end
    end
  end

  // ====================
  // strobe sequencing
  logic       msTick;
  logic [10:0] msInStrobe;
  logic [2:0] strobeIdx;
  logic       lastMs;
  logic       inWindow;

  bsps_ms_tick #(.CYCLES(MS_CYCLES)) u_tick (
    .core_clk (core_clk),
    .resetn   (resetn),
    .msTick   (msTick)
  );

  // period clamped so a bad write can never shorten the read window
  logic [10:0] effPeriod;
  always_comb begin
    effPeriod = switchScanPeriodParam; // [RULE1]
    if (effPeriod < 11'(`BSPS_SCAN_MIN_MS))
      effPeriod = 11'(`BSPS_SCAN_MIN_MS);
    else if (effPeriod > 11'(`BSPS_SCAN_MAX_MS))
      effPeriod = 11'(`BSPS_SCAN_MAX_MS);
  end

  assign lastMs   = (msInStrobe >= effPeriod - 11'h001);
  // only the final window of each strobe is sampled          [RULE4] [RULE2]
  assign inWindow = (msInStrobe >= effPeriod - 11'(`BSPS_READ_WIN_MS));

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      msInStrobe <= 11'h000;
      strobeIdx  <= 3'h0;
    end else if (msTick) begin
      if (lastMs) begin
        msInStrobe <= 11'h000;
        strobeIdx  <= (strobeIdx == 3'h4) ? 3'h0 : strobeIdx + 3'h1; // [RULE16]
      end else begin
        msInStrobe <= msInStrobe + 11'h001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) strobeLineN <= 5'h1F;
    else strobeLineN <= ~(5'h01 << strobeIdx); // [RULE16]
  end

  // ====================
  // digit capture at end of window, once settled
  logic [7:0] posDig [5];
  logic [7:0] spdDig [5];
  logic       cycleDone;
  logic [4:0] seenMask;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      for (int i = 0; i < 5; i++) begin
        posDig[i] <= 8'h00;
        spdDig[i] <= 8'h00;
      end
      seenMask  <= 5'h00;
      cycleDone <= 1'b0;
    end else begin
      cycleDone <= 1'b0;
      if (msTick && lastMs && inWindow) begin
        posDig[strobeIdx] <= pinStable[7:0]; // [RULE17]
        spdDig[strobeIdx] <= pinStable[15:8]; // [RULE17]
        if (strobeIdx == 3'h4) begin
          cycleDone <= (seenMask == 5'h0F); // [RULE19]
          seenMask  <= 5'h00;
        end else begin
          seenMask  <= seenMask | (5'h01 << strobeIdx);
        end
      end
    end
  end

  // ====================
  // decode: bcd or binary; strobe 4 position digits carry the sign
  function automatic logic [31:0] bcdVal(input logic [7:0] d [5],
                                         input int n);
    logic [31:0] acc;
    acc = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      acc = acc * 32'd100 + 32'(d[i][7:4]) * 32'd10 + 32'(d[i][3:0]);
    end
    return acc;
  endfunction

  logic        useBcd;
  logic        incMode;
  logic        retainCoord;
  logic [31:0] posMag, spdMag;
  logic        posNeg;
  assign useBcd      = memorySwitchWord[`BSPS_CFG_CODE_BIT];  // [RULE5]
  assign incMode     = memorySwitchWord[`BSPS_CFG_MODE_BIT];  // [RULE6]
  assign retainCoord = memorySwitchWord[`BSPS_CFG_RETAIN_BIT]; // [RULE11]

  always_comb begin
    if (useBcd) begin // [RULE5]
      posMag = bcdVal(posDig, 4);
      spdMag = bcdVal(spdDig, 3);
    end else begin
      posMag = {posDig[3], posDig[2], posDig[1], posDig[0]};
      spdMag = {8'h00, spdDig[2], spdDig[1], spdDig[0]};
    end
    // single speed-only stage: its sign digit is ignored     [RULE12]
    posNeg = speedOnlyStage ? 1'b0 : posDig[4][0];
  end

  // ====================
  // latch monitors after a whole cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      monitorCmdPosition <= 32'h0;
      monitorCmdSpeed    <= 32'h0;
      cmdValid           <= 1'b0;
    end else if (cycleDone) begin // [RULE19]
      monitorCmdPosition <= posNeg ? -posMag : posMag;
      monitorCmdSpeed    <= spdMag;
      cmdValid           <= 1'b1;
    end
  end

  // ====================
  // speed source selection
  always_ff @(posedge core_clk) begin
    if (!resetn) feedSpeed <= 32'h0;
    else case (spdSrc)
      BSPS_SPD_SWITCH: feedSpeed <= monitorCmdSpeed;          // [RULE13]
      BSPS_SPD_STORED: feedSpeed <= storedSpeed[speedSelIn];  // [RULE14]
      BSPS_SPD_SERIAL: feedSpeed <= serialSpeedCmd;           // [RULE14]
      default:         feedSpeed <= monitorCmdSpeed;
    endcase
  end

  // ====================
  // coordinate and motion
  logic signed [31:0] startBase;
  assign startBase = (incMode && !retainCoord) ? 32'sh0 : curPos; // [RULE10]

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      curPos    <= 32'sh0;
      targetPos <= 32'sh0;
      motion    <= BSPS_IDLE;
    end else if (autoStart) begin
      curPos <= startBase; // [RULE10]
      if (incMode) begin
        targetPos <= startBase + $signed(monitorCmdPosition); // [RULE8]
        if (monitorCmdPosition == 32'h0) motion <= BSPS_IDLE;
        else if (monitorCmdPosition[31]) motion <= BSPS_RUN_REV; // [RULE9]
        else motion <= BSPS_RUN_FWD; // [RULE9]
      end else begin
        targetPos <= $signed(monitorCmdPosition);
        if (curPos < $signed(monitorCmdPosition))
          motion <= BSPS_RUN_FWD; // [RULE7]
        else if (curPos > $signed(monitorCmdPosition))
          motion <= BSPS_RUN_REV; // [RULE7]
        else motion <= BSPS_IDLE;
      end
    end else begin
      if (stepFwd && !stepRev) curPos <= curPos + 32'sh1;
      else if (stepRev && !stepFwd) curPos <= curPos - 32'sh1;
      case (motion)
        BSPS_RUN_FWD: if (curPos >= targetPos) motion <= BSPS_IDLE;
        BSPS_RUN_REV: if (curPos <= targetPos) motion <= BSPS_IDLE;
        default:      motion <= BSPS_IDLE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) motionDir <= 2'h0;
    else case (motion)
      BSPS_RUN_FWD: motionDir <= 2'h1;
      BSPS_RUN_REV: motionDir <= 2'h2;
      default:      motionDir <= 2'h0;
    endcase
  end

  // ====================
  // AXI4-Lite write: address and data taken in either order
  logic       awHeld, wHeld;
  logic [7:0] awAddr;
  logic [31:0] wData;
  logic [3:0] wStrb;
  logic       doWrite;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld  <= 1'b0;
      awAddr <= 8'h00;
      wData  <= 32'h0;
      wStrb  <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'h0;
    end else begin
      s_axi_awready <= !awHeld && !s_axi_awready;
      s_axi_wready  <= !wHeld && !s_axi_wready;
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddr <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wData <= s_axi_wdata;
        wStrb <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (doWrite) begin
        awHeld       <= 1'b0;
        wHeld        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (awAddr <= 8'(`BSPS_REG_SERSPD)) ? 2'h0 : 2'h2;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) if (s[b]) old[b*8 +: 8] = d[b*8 +: 8];
    return old;
  endfunction

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      memorySwitchWord      <= `BSPS_CFG_RESET;
      switchScanPeriodParam <= `BSPS_SCAN_DEF_MS;             // [RULE1]
      speedOnlyStage        <= 1'b0;
      spdSrc                <= BSPS_SPD_SWITCH;               // [RULE13]
      serialSpeedCmd        <= 32'h0;
      for (int i = 0; i < 4; i++) storedSpeed[i] <= 32'h0;
    end else if (doWrite) begin
      case (awAddr)
        8'(`BSPS_REG_CFG):
          memorySwitchWord <= 8'(merge({24'h0, memorySwitchWord}, wData,
                                       wStrb) & 32'h19);
        8'(`BSPS_REG_SCAN):
          switchScanPeriodParam <= 11'(merge({21'h0,
                                   switchScanPeriodParam}, wData, wStrb));
        8'(`BSPS_REG_SPDSEL): if (wStrb[0]) begin
          speedOnlyStage <= wData[2];
          spdSrc <= (wData[1:0] == 2'h1) ? BSPS_SPD_STORED :
                    (wData[1:0] == 2'h2) ? BSPS_SPD_SERIAL : BSPS_SPD_SWITCH;
        end
        8'(`BSPS_REG_SERSPD):
          serialSpeedCmd <= merge(serialSpeedCmd, wData, wStrb);
        default: begin
          for (int i = 0; i < 4; i++)
            if (awAddr == 8'(`BSPS_REG_STORED0) + 8'(i * 4))
              storedSpeed[i] <= merge(storedSpeed[i], wData, wStrb);
        end
      endcase
    end
  end

  // ====================
  // AXI4-Lite read: one cycle from address taken to data valid
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= 2'h0;
    end else begin
      s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= 2'h0;
        case (s_axi_araddr)
          8'(`BSPS_REG_CFG):    s_axi_rdata <= {24'h0, memorySwitchWord};
          8'(`BSPS_REG_SCAN):   s_axi_rdata <= {21'h0, switchScanPeriodParam};
          8'(`BSPS_REG_SPDSEL): s_axi_rdata <= {29'h0, speedOnlyStage,
                                                 2'(spdSrc)};
          8'(`BSPS_REG_MONPOS): s_axi_rdata <= monitorCmdPosition;
          8'(`BSPS_REG_MONSPD): s_axi_rdata <= monitorCmdSpeed;
          8'(`BSPS_REG_CURPOS): s_axi_rdata <= curPos;
          8'(`BSPS_REG_TARGET): s_axi_rdata <= targetPos;
          8'(`BSPS_REG_STATUS): s_axi_rdata <= {21'h0, strobeIdx, 5'h0,
                                                 cmdValid, motionDir};
          8'h24: s_axi_rdata <= storedSpeed[0];
          8'h28: s_axi_rdata <= storedSpeed[1];
          8'h2C: s_axi_rdata <= storedSpeed[2];
          8'h30: s_axi_rdata <= storedSpeed[3];
          8'(`BSPS_REG_SERSPD): s_axi_rdata <= serialSpeedCmd;
          default: begin
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h2;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : bsps_scanner

// ==== verif/bsps_scanner_properties.sv ====
// port checker for the switch position scanner
`timescale 1ns/1ps
module bsps_scanner_checker #(
  parameter int unsigned MS_CYCLES = 200000
) (
  input wire logic       core_clk,      // clock
  input wire logic       resetn,        // sync reset, active low
  input wire logic [4:0] strobeLineN,   // strobes
  input wire logic       autoStart,     // start pulse
  input wire logic       cmdValid,      // capture done
  input wire logic [1:0] motionDir,     // direction
  input wire logic       s_axi_awvalid, // aw valid
  input wire logic       s_axi_awready, // aw ready
  input wire logic       s_axi_wvalid,  // w valid
  input wire logic       s_axi_wready,  // w ready
  input wire logic       s_axi_bvalid,  // b valid
  input wire logic       s_axi_arvalid, // ar valid
  input wire logic       s_axi_arready, // ar ready
  input wire logic       s_axi_rvalid   // r valid
);
  // ====================
  // how long the last strobe pattern stood
  localparam int MINW = 12 * MS_CYCLES - 1;
  logic [4:0]  prevStb;
  int unsigned widthCnt;
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      prevStb  <= 5'h1F;
      widthCnt <= 0;
    end else begin
      prevStb  <= strobeLineN;
      widthCnt <= (strobeLineN != prevStb) ? 1 : widthCnt + 1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // ====================
  property p_one_low;
    strobeLineN == 5'h1F || $countones(~strobeLineN) == 1;
  endproperty
  a_one_low: assert property (p_one_low)
    else $error("more than one strobe low");
  property p_order;
    strobeLineN != prevStb && prevStb != 5'h1F
      |-> strobeLineN == {prevStb[3:0], prevStb[4]};
  endproperty
  a_order: assert property (p_order)
    else $error("strobe order broken");
  property p_width;
    strobeLineN != prevStb && prevStb != 5'h1F |-> widthCnt >= MINW;
  endproperty
  a_width: assert property (p_width)
    else $error("strobe shorter than read window");
  property p_dir_cause;
    $past(motionDir) != motionDir && motionDir != 2'h0
      |-> $past(autoStart) || $past(autoStart, 2);
  endproperty
  a_dir_cause: assert property (p_dir_cause)
    else $error("motion started without start");
  property p_dir_code;
    motionDir != 2'h3;
  endproperty
  a_dir_code: assert property (p_dir_code)
    else $error("illegal direction code");
  property p_valid_end;
    $rose(cmdValid) |-> !strobeLineN[4] || !strobeLineN[0];
  endproperty
  a_valid_end: assert property (p_valid_end)
    else $error("capture outside cycle end");
  property p_bresp;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |-> ##2 s_axi_bvalid;
  endproperty
  a_bresp: assert property (p_bresp)
    else $error("write response late");
  property p_rresp;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rresp: assert property (p_rresp)
    else $error("read data late");
  c_valid: cover property ($rose(cmdValid));
  c_rev: cover property (motionDir == 2'h2);
  c_read: cover property (s_axi_rvalid);
endmodule : bsps_scanner_checker

bind bsps_scanner bsps_scanner_checker #(.MS_CYCLES(MS_CYCLES)) u_chk (
  .core_clk(core_clk), .resetn(resetn), .strobeLineN(strobeLineN),
  .autoStart(autoStart), .cmdValid(cmdValid), .motionDir(motionDir),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));

// ==== verif/bsps_switch_model.sv ====
// switch unit model: digit lines for whichever strobe is low
`timescale 1ns/1ps
module bsps_switch_model (
  input  wire logic        core_clk,    // clock
  input  wire logic [4:0]  strobeLineN, // strobes from scanner
  input  wire logic [39:0] posTab,      // position byte per strobe
  input  wire logic [39:0] spdTab,      // speed byte per strobe
  input  wire logic [31:0] settle,      // cycles before lines are valid
  output logic [7:0]       posDigitInN, // position lines
  output logic [7:0]       spdDigitInN  // speed lines
);
  logic [4:0]  lastStb = 5'h1F;
  logic [31:0] age = 32'h0;
  always_ff @(posedge core_clk) begin
    lastStb <= strobeLineN;
    age     <= (strobeLineN != lastStb) ? 32'h0 : age + 32'h1;
  end
  // a slow source shows a toggling wrong pattern until it settles
  always_comb begin
    posDigitInN = 8'hFF;
    spdDigitInN = 8'hFF;
    for (int k = 0; k < 5; k++) begin
      if (!strobeLineN[k]) begin
        posDigitInN = ~posTab[8*k +: 8];
        spdDigitInN = ~spdTab[8*k +: 8];
        if (age < settle) begin
          posDigitInN = posTab[8*k +: 8] ^ {8{age[0]}};
          spdDigitInN = spdTab[8*k +: 8] ^ {8{age[0]}};
        end
      end
    end
  end
endmodule : bsps_switch_model

// ==== verif/testbench.sv ====
// self-checking bench for the switch position scanner
`timescale 1ns/1ps
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin \
  failures++; $display("BAD %s exp %0h got %0h", n, e, s); end end
module testbench;
  localparam int MSC = 20;
  logic core_clk = 1'b0, resetn = 1'b0, autoStart = 1'b0;
  logic stepFwd = 1'b0, stepRev = 1'b0, cmdValid;
  logic [1:0] speedSelIn = 2'h0, motionDir, s_axi_bresp, s_axi_rresp, rsp;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, feedSpeed, rdv;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  logic [4:0] strobeLineN;
  logic [7:0] posDigitInN, spdDigitInN;
  logic [39:0] posTab = 40'h34, spdTab = 40'h12;
  logic [31:0] settle = 32'h0;
  int failures = 0, cmp_count = 0, cyc = 0;
  always #2.5 core_clk = ~core_clk;
  bsps_scanner #(.MS_CYCLES(MSC)) uut (.core_clk(core_clk),
    .resetn(resetn), .strobeLineN(strobeLineN), .posDigitInN(posDigitInN),
    .spdDigitInN(spdDigitInN), .autoStart(autoStart), .stepFwd(stepFwd),
    .stepRev(stepRev), .speedSelIn(speedSelIn), .cmdValid(cmdValid),
    .motionDir(motionDir), .feedSpeed(feedSpeed),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
  bsps_switch_model u_sw (.core_clk(core_clk), .strobeLineN(strobeLineN),
    .posTab(posTab), .spdTab(spdTab), .settle(settle),
    .posDigitInN(posDigitInN), .spdDigitInN(spdDigitInN));
  // ====================
  task automatic clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask : clk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad = 1'b0, wd = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge core_clk);
      if (s_axi_awready) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (s_axi_wready) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    while (!s_axi_bvalid) @(posedge core_clk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge core_clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    while (!s_axi_rvalid) @(posedge core_clk);
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd
  task automatic chkReg(input string n, input logic [7:0] a,
                        input logic [31:0] e);
    rd(a);
    `CHK(n, e, rdv)
  endtask : chkReg
  function automatic logic [3:0] dig(input int v, input int i);
    return 4'((v / (10 ** i)) % 10);
  endfunction : dig
  // two scan cycles hold one clean cycle
  task automatic setBcd(input int p, input int s, input bit neg, int ms);
    for (int k = 0; k < 4; k++) begin
      posTab[8*k +: 8] <= {dig(p, 2*k+1), dig(p, 2*k)};
      spdTab[8*k +: 8] <= (k < 3) ? {dig(s, 2*k+1), dig(s, 2*k)} : 8'h00;
    end
    posTab[39:32] <= {7'h00, neg};
    clk(10 * ms * MSC + 50);
  endtask : setBcd
  task automatic start();
    @(posedge core_clk);
    autoStart <= 1'b1;
    @(posedge core_clk);
    autoStart <= 1'b0;
    clk(4);
  endtask : start
  task automatic steps(input bit fwd, input int n);
    repeat (n) begin
      @(posedge core_clk);
      if (fwd) stepFwd <= 1'b1;
      else stepRev <= 1'b1;
      @(posedge core_clk);
      stepFwd <= 1'b0;
      stepRev <= 1'b0;
    end
    clk(4);
  endtask : steps
  task automatic measure(input int ms);
    int n = 0;
    do @(posedge core_clk); while (strobeLineN[1]);
    while (!strobeLineN[1]) begin n++; @(posedge core_clk); end
    `CHK("strobe width", ms * MSC, n)
  endtask : measure
  task results;
    if (failures == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : results
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 60000) begin failures++; results(); end
  end
  // ====================
  initial begin
    clk(8);
    resetn <= 1'b1;
    clk(2);
    chkReg("cfg", 8'h00, 32'h0);
    chkReg("scan", 8'h04, 32'hC);
    chkReg("unmapped", 8'h40, 32'h0);
    `CHK("rd resp", 2'h2, rsp)
    wr(8'h40, 32'h1);
    `CHK("wr resp", 2'h2, rsp)
    measure(12);
    clk(3 * 5 * 12 * MSC);
    `CHK("valid", 1'b1, cmdValid)
    chkReg("bin pos", 8'h10, 32'h34);
    chkReg("bin spd", 8'h14, 32'h12);
    wr(8'h00, 32'h10);
    setBcd(12345678, 654321, 1'b0, 12);
    chkReg("bcd pos", 8'h10, 32'd12345678);
    chkReg("bcd spd", 8'h14, 32'd654321);
    `CHK("switch spd", 32'd654321, feedSpeed)
    for (int i = 0; i < 4; i++) wr(8'(8'h24 + 4 * i), 32'(100 + i));
    wr(8'h34, 32'h777);
    wr(8'h0C, 32'h1);
    for (int i = 0; i < 4; i++) begin
      speedSelIn <= 2'(i);
      clk(4);
      `CHK("stored spd", 32'(100 + i), feedSpeed)
    end
    wr(8'h0C, 32'h2);
    clk(4);
    `CHK("serial spd", 32'h777, feedSpeed)
    wr(8'h0C, 32'h0);
    setBcd(3, 5, 1'b0, 12);
    start();
    chkReg("abs target", 8'h1C, 32'd3);
    `CHK("abs fwd", 2'h1, motionDir)
    steps(1'b1, 3);
    setBcd(1, 5, 1'b0, 12);
    start();
    `CHK("abs rev", 2'h2, motionDir)
    steps(1'b0, 2);
    wr(8'h00, 32'h18);
    setBcd(7, 5, 1'b0, 12);
    start();
    chkReg("cleared", 8'h18, 32'd0);
    chkReg("inc target", 8'h1C, 32'd7);
    `CHK("inc fwd", 2'h1, motionDir)
    steps(1'b1, 7);
    wr(8'h00, 32'h19);
    setBcd(4, 5, 1'b1, 12);
    chkReg("neg pos", 8'h10, -32'sd4);
    start();
    chkReg("kept", 8'h18, 32'd7);
    chkReg("neg target", 8'h1C, 32'd3);
    `CHK("inc rev", 2'h2, motionDir)
    wr(8'h0C, 32'h4);
    clk(5 * 12 * MSC + 50);
    chkReg("sign off", 8'h10, 32'd4);
    wr(8'h0C, 32'h0);
    wr(8'h04, 32'd42);
    settle <= 32'(29 * MSC);
    setBcd(24680, 1357, 1'b1, 42);
    chkReg("late pos", 8'h10, -32'sd24680);
    chkReg("late spd", 8'h14, 32'd1357);
    measure(42);
    results();
  end
endmodule : testbench
